// ---- rtl/arf_pkg.sv ----
// shared constants, types and helpers for the converter result formatter
package arf_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ARF_SAMPLE_W = 12;
    localparam int ARF_RESULT_W = 16;
    localparam int ARF_ADDR_W   = 8;
    localparam int ARF_DATA_W   = 32;
    localparam int ARF_CNT_W    = 4;
    localparam int ARF_RPT_W    = 2;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] ARF_OFF_CTRL   = 8'h00;
    localparam logic [7:0] ARF_OFF_CFG    = 8'h04;
    localparam logic [7:0] ARF_OFF_RES_HI = 8'h08;
    localparam logic [7:0] ARF_OFF_RES_LO = 8'h0C;
    localparam logic [7:0] ARF_OFF_STATUS = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int ARF_RESTART_BIT = 1;
    localparam int ARF_LJST_BIT    = 2;
    localparam int ARF_RPT_LSB     = 0;
    localparam int ARF_CNT_LSB     = 0;
    localparam int ARF_BUSY_BIT    = 4;
    localparam int ARF_VALID_BIT   = 8;
    localparam int ARF_OVR_BIT     = 9;
    localparam int ARF_LJST_SHIFT  = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic             ARF_LJST_RST   = 1'b0;
    localparam logic [1:0]       ARF_RPT_RST    = 2'h0;
    localparam logic [15:0]      ARF_RESULT_RST = 16'h0000;
    localparam logic [31:0]      ARF_RDATA_RST  = 32'h00000000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0]
    {
        ARF_RPT_1  = 2'h0,
        ARF_RPT_4  = 2'h1,
        ARF_RPT_8  = 2'h2,
        ARF_RPT_16 = 2'h3
    } arf_rpt_t;

    typedef enum logic [1:0]
    {
        ARF_ST_IDLE = 2'b01,
        ARF_ST_ACC  = 2'b10
    } arf_state_t;

    typedef struct packed
    {
        logic                  psel;
        logic                  penable;
        logic                  pwrite;
        logic [ARF_ADDR_W-1:0] paddr;
        logic [ARF_DATA_W-1:0] pwdata;
    } arf_apb_req_t;

    typedef struct packed
    {
        logic                  pready;
        logic [ARF_DATA_W-1:0] prdata;
        logic                  pslverr;
    } arf_apb_rsp_t;

    // index of the last sample in a series for a repeat selection
    function automatic logic [ARF_CNT_W-1:0] arf_rpt_last(input arf_rpt_t r);
        case (r)
            ARF_RPT_4:  arf_rpt_last = 4'h3;
            ARF_RPT_8:  arf_rpt_last = 4'h7;
            ARF_RPT_16: arf_rpt_last = 4'hF;
            default:    arf_rpt_last = 4'h0;
        endcase
    endfunction

endpackage

// ---- rtl/arf_accum.sv ----
// series accumulator: sums converter samples and publishes per series
`timescale 1ns/1ps
module arf_accum
    import arf_pkg::*;
#(
    parameter int SAMPLE_W = ARF_SAMPLE_W,
    parameter int RESULT_W = ARF_RESULT_W
)
(
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_sample_vld,
    input  wire logic [SAMPLE_W-1:0]  i_sample,
    input  wire arf_rpt_t             i_rpt,
    input  wire logic                 i_restart,
    output logic                      o_pub,
    output logic                      o_single,
    output logic [RESULT_W-1:0]       o_sum,
    output logic [ARF_CNT_W-1:0]      o_count,
    output logic                      o_busy
);

    arf_state_t             state_r;
    logic [RESULT_W-1:0]    acc_r;
    logic [RESULT_W-1:0]    sum_nxt;
    logic [RESULT_W-1:0]    samp_ext;
    logic [ARF_CNT_W-1:0]   last;

    assign samp_ext = RESULT_W'(i_sample);
    assign sum_nxt  = acc_r + samp_ext;
    assign last     = arf_rpt_last(i_rpt);
    assign o_busy   = (state_r == ARF_ST_ACC);

    // ****************************************
    // series sequencing
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            state_r <= ARF_ST_IDLE;
            acc_r   <= '0;
            o_count <= '0;
        end
        else if (i_restart)
        begin
            // a restart drops any partial sum
            state_r <= ARF_ST_IDLE;
            acc_r   <= '0;
            o_count <= '0;
        end
        else if (i_sample_vld)
        begin
            case (state_r)
                ARF_ST_IDLE:
                begin
                    if (last != '0)
                    begin
                        // first sample loads, so series never mix
                        acc_r   <= samp_ext;
                        o_count <= 4'h1;
                        state_r <= ARF_ST_ACC;
                    end
                end
                ARF_ST_ACC:
                begin
                    if (o_count == last)
                    begin
                        acc_r   <= '0;
                        o_count <= '0;
                        state_r <= ARF_ST_IDLE;
                    end
                    else
                    begin
                        acc_r   <= sum_nxt;
                        o_count <= o_count + 4'h1;
                    end
                end
                default:
                begin
                    state_r <= ARF_ST_IDLE;
                    acc_r   <= '0;
                    o_count <= '0;
                end
            endcase
        end
    end

    // ****************************************
    // publish strobe and value
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_pub    <= 1'b0;
            o_single <= 1'b0;
            o_sum    <= '0;
        end
        else
        begin
            o_pub <= 1'b0;
            if (!i_restart && i_sample_vld)
            begin
                if (state_r == ARF_ST_IDLE && last == '0)
                begin
                    o_pub    <= 1'b1;
                    o_single <= 1'b1;
                    o_sum    <= samp_ext;
                end
                else if (state_r == ARF_ST_ACC && o_count == last)
                begin
                    o_pub    <= 1'b1;
                    o_single <= 1'b0;
                    o_sum    <= sum_nxt;
                end
            end
        end
    end

endmodule

// ---- rtl/arf_top.sv ----
// converter result formatter: APB registers, justification and publish
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module arf_top
    import arf_pkg::*;
#(
    parameter int SAMPLE_W = ARF_SAMPLE_W,
    parameter int RESULT_W = ARF_RESULT_W
)
(
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    input  wire arf_apb_req_t         i_apb_req,
    input  wire logic                 i_conv_done,
    input  wire logic [SAMPLE_W-1:0]  i_conv_code,
    output arf_apb_rsp_t              o_apb_rsp,
    output logic [RESULT_W-1:0]       o_result
);

    // ****************************************
    // elaboration check
    // ****************************************
    generate
        if (RESULT_W != 16 || SAMPLE_W + ARF_LJST_SHIFT > RESULT_W)
        begin : g_bad_width
            $error("arf_top: result must be 16 bits and hold 16 samples");
        end
    endgenerate

    // ****************************************
    // declarations
    // ****************************************
    logic                   ljst_r;
    arf_rpt_t               rpt_r;
    logic                   valid_r;
    logic                   ovr_r;
    logic                   restart_nxt;
    logic                   acc_pub;
    logic                   acc_single;
    logic [RESULT_W-1:0]    acc_sum;
    logic [ARF_CNT_W-1:0]   acc_count;
    logic                   acc_busy;
    logic [RESULT_W-1:0]    fmt_nxt;
    logic                   apb_acc;
    logic                   wr_commit;
    logic                   rd_launch;
    logic                   clr_valid;
    logic                   clr_ovr;
    logic [ARF_DATA_W-1:0]  rdata_nxt;
    logic                   addr_err;
    logic [ARF_DATA_W-1:0]  wdata;

    // true when the request hits the given aligned word offset
    function automatic logic hit(input logic [ARF_ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ****************************************
    // bus phase decode
    // ****************************************
    // one wait state: pready rises in the second access cycle, so reads
    // are registered and every output stays a flip-flop
    assign apb_acc   = i_apb_req.psel & i_apb_req.penable;
    assign rd_launch = apb_acc & ~o_apb_rsp.pready;
    assign wr_commit = apb_acc & o_apb_rsp.pready & i_apb_req.pwrite
                       & ~o_apb_rsp.pslverr;
    assign wdata     = i_apb_req.pwdata;

    always_comb
    begin
        addr_err = 1'b1;
        if (hit(i_apb_req.paddr, ARF_OFF_CTRL)
            || hit(i_apb_req.paddr, ARF_OFF_CFG)
            || hit(i_apb_req.paddr, ARF_OFF_STATUS))
        begin
            addr_err = 1'b0;
        end
        else if (hit(i_apb_req.paddr, ARF_OFF_RES_HI)
                 || hit(i_apb_req.paddr, ARF_OFF_RES_LO))
        begin
            // result bytes are read-only; a write is an error
            addr_err = i_apb_req.pwrite;
        end
    end

    // ****************************************
    // control and config registers
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            ljst_r <= ARF_LJST_RST;
        end
        else if (wr_commit && hit(i_apb_req.paddr, ARF_OFF_CTRL))
        begin
            ljst_r <= wdata[ARF_LJST_BIT];
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            rpt_r <= arf_rpt_t'(ARF_RPT_RST);
        end
        else if (wr_commit && hit(i_apb_req.paddr, ARF_OFF_CFG))
        begin
            rpt_r <= arf_rpt_t'(wdata[ARF_RPT_LSB +: ARF_RPT_W]);
        end
    end

    // a new repeat setting or an explicit restart starts a fresh series
    always_comb
    begin
        restart_nxt = 1'b0;
        if (wr_commit && hit(i_apb_req.paddr, ARF_OFF_CFG))
        begin
            restart_nxt = 1'b1;
        end
        else if (wr_commit && hit(i_apb_req.paddr, ARF_OFF_CTRL)
                 && wdata[ARF_RESTART_BIT])
        begin
            restart_nxt = 1'b1;
        end
    end

    // ****************************************
    // accumulator
    // ****************************************
    arf_accum #(
        .SAMPLE_W (SAMPLE_W),
        .RESULT_W (RESULT_W)
    ) u_accum (
        .i_clk_sys    (i_clk_sys),
        .i_rst_n      (i_rst_n),
        .i_sample_vld (i_conv_done),
        .i_sample     (i_conv_code),
        .i_rpt        (rpt_r),
        .i_restart    (restart_nxt),
        .o_pub        (acc_pub),
        .o_single     (acc_single),
        .o_sum        (acc_sum),
        .o_count      (acc_count),
        .o_busy       (acc_busy)
    );

    // ****************************************
    // justification
    // ****************************************
    always_comb
    begin
        // series sums are always right-justified; software is expected
        // to keep justify clear then, and the hardware does not rely on it
        fmt_nxt = acc_sum;
        if (acc_single)
        begin
            if (ljst_r)
            begin
                fmt_nxt = {acc_sum[SAMPLE_W-1:0],
                           {(RESULT_W-SAMPLE_W){1'b0}}};
            end
            else
            begin
                fmt_nxt = {{(RESULT_W-SAMPLE_W){1'b0}},
                           acc_sum[SAMPLE_W-1:0]};
            end
        end
    end

    // ****************************************
    // result register
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_result <= ARF_RESULT_RST;
        end
        else if (acc_pub)
        begin
            o_result <= fmt_nxt;
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    assign clr_valid = wr_commit && hit(i_apb_req.paddr, ARF_OFF_STATUS)
                       && wdata[ARF_VALID_BIT];
    assign clr_ovr   = wr_commit && hit(i_apb_req.paddr, ARF_OFF_STATUS)
                       && wdata[ARF_OVR_BIT];

    // a publish in the clearing cycle keeps the flag set
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            valid_r <= 1'b0;
        end
        else if (acc_pub)
        begin
            valid_r <= 1'b1;
        end
        else if (clr_valid)
        begin
            valid_r <= 1'b0;
        end
    end

    // overrun marks a result replaced before software acknowledged it
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            ovr_r <= 1'b0;
        end
        else if (acc_pub && valid_r && !clr_valid)
        begin
            ovr_r <= 1'b1;
        end
        else if (clr_ovr)
        begin
            ovr_r <= 1'b0;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb
    begin
        rdata_nxt = '0;
        if (hit(i_apb_req.paddr, ARF_OFF_CTRL))
        begin
            rdata_nxt[ARF_LJST_BIT] = ljst_r;
        end
        else if (hit(i_apb_req.paddr, ARF_OFF_CFG))
        begin
            rdata_nxt[ARF_RPT_LSB +: ARF_RPT_W] = rpt_r;
        end
        else if (hit(i_apb_req.paddr, ARF_OFF_RES_HI))
        begin
            rdata_nxt[7:0] = o_result[15:8];
        end
        else if (hit(i_apb_req.paddr, ARF_OFF_RES_LO))
        begin
            rdata_nxt[7:0] = o_result[7:0];
        end
        else if (hit(i_apb_req.paddr, ARF_OFF_STATUS))
        begin
            rdata_nxt[ARF_CNT_LSB +: ARF_CNT_W] = acc_count;
            rdata_nxt[ARF_BUSY_BIT]             = acc_busy;
            rdata_nxt[ARF_VALID_BIT]            = valid_r;
            rdata_nxt[ARF_OVR_BIT]              = ovr_r;
        end
    end

    // ****************************************
    // bus response
    // ****************************************
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_apb_rsp.pready <= 1'b0;
        end
        else
        begin
            o_apb_rsp.pready <= rd_launch;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            o_apb_rsp.prdata  <= ARF_RDATA_RST;
            o_apb_rsp.pslverr <= 1'b0;
        end
        else if (rd_launch)
        begin
            o_apb_rsp.pslverr <= addr_err;
            if (i_apb_req.pwrite || addr_err)
            begin
                o_apb_rsp.prdata <= ARF_RDATA_RST;
            end
            else
            begin
                o_apb_rsp.prdata <= rdata_nxt;
            end
        end
        else if (!apb_acc)
        begin
            o_apb_rsp.pslverr <= 1'b0;
        end
    end

endmodule

// ---- bench/arf_top_sva.sv ----
// checker for register answers and result publishing of the formatter
`timescale 1ns/1ps
module arf_top_sva
    import arf_pkg::*;
#(
    parameter int SAMPLE_W = ARF_SAMPLE_W,
    parameter int RESULT_W = ARF_RESULT_W
)
(
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst_n,
    input  wire arf_apb_req_t        i_apb_req,
    input  wire logic                i_conv_done,
    input  wire logic [SAMPLE_W-1:0] i_conv_code,
    input  wire arf_apb_rsp_t        o_apb_rsp,
    input  wire logic [RESULT_W-1:0] o_result
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // ****************************************
    // mirror of software settings and series
    // ****************************************
    logic                take_w;
    logic                wr_rst_w;
    logic                hit_w;
    logic [3:0]          last_w;
    logic [7:0]          a_w;
    logic                ljst_r;
    logic [1:0]          rpt_r;
    logic [3:0]          cnt_r;
    logic [2:0]          hit_r;
    logic [RESULT_W-1:0] acc_r;
    logic [RESULT_W-1:0] sum_r;
    logic [RESULT_W-1:0] exp_r;

    assign a_w      = i_apb_req.paddr;
    assign take_w   = i_apb_req.psel & i_apb_req.penable
                    & o_apb_rsp.pready & i_apb_req.pwrite;
    // a restart write in the sample's cycle drops that sample
    assign wr_rst_w = take_w & ((a_w == ARF_OFF_CFG) | ((a_w == ARF_OFF_CTRL)
                    & i_apb_req.pwdata[ARF_RESTART_BIT]));
    assign last_w   = 4'((5'h2 << rpt_r) - 5'h1);
    assign hit_w    = i_conv_done & ~wr_rst_w & (rpt_r != 2'h0)
                    & (cnt_r == last_w);

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            ljst_r <= 1'b0;
            rpt_r  <= 2'h0;
        end
        else
        begin
            if (take_w && a_w == ARF_OFF_CTRL)
                ljst_r <= i_apb_req.pwdata[ARF_LJST_BIT];
            if (take_w && a_w == ARF_OFF_CFG)
                rpt_r <= i_apb_req.pwdata[1:0];
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n || wr_rst_w)
        begin
            cnt_r <= 4'h0;
            acc_r <= '0;
        end
        else if (i_conv_done && rpt_r != 2'h0)
        begin
            cnt_r <= hit_w ? 4'h0 : cnt_r + 4'h1;
            acc_r <= hit_w ? '0 : acc_r + RESULT_W'(i_conv_code);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        hit_r <= i_rst_n ? {hit_r[1:0], hit_w} : 3'h0;
        if (hit_w)
            sum_r <= acc_r + RESULT_W'(i_conv_code);
        if (i_conv_done)
            exp_r <= RESULT_W'(i_conv_code) << (ljst_r ? ARF_LJST_SHIFT : 0);
    end

    // ****************************************
    // assertions
    // ****************************************
    a_ready_wait: assert property (
        i_apb_req.psel && i_apb_req.penable && !o_apb_rsp.pready
        |=> o_apb_rsp.pready) else $error("pready late");
    a_ready_pulse: assert property (
        o_apb_rsp.pready |=> !o_apb_rsp.pready) else $error("pready held");
    a_refuse_err: assert property (
        o_apb_rsp.pready && ((i_apb_req.pwrite && (a_w == ARF_OFF_RES_HI
        || a_w == ARF_OFF_RES_LO)) || a_w > ARF_OFF_STATUS)
        |-> o_apb_rsp.pslverr && o_apb_rsp.prdata == 32'h0)
        else $error("refusal missing");
    a_read_high: assert property (
        o_apb_rsp.pready && !i_apb_req.pwrite && a_w == ARF_OFF_RES_HI
        && $stable(o_result) |-> o_apb_rsp.prdata == {24'h0, o_result[15:8]})
        else $error("high byte wrong");
    a_read_low: assert property (
        o_apb_rsp.pready && !i_apb_req.pwrite && a_w == ARF_OFF_RES_LO
        && $stable(o_result) |-> o_apb_rsp.prdata == {24'h0, o_result[7:0]})
        else $error("low byte wrong");
    a_single_fmt: assert property (
        i_conv_done && rpt_r == 2'h0 && !take_w ##1 !take_w ##1 !take_w
        |=> o_result == $past(exp_r, 2)) else $error("single result wrong");
    a_series_sum: assert property (
        hit_r[2] && !$past(wr_rst_w) && !$past(wr_rst_w, 2)
        |-> o_result == sum_r) else $error("series sum wrong");
    a_series_once: assert property (
        $changed(o_result) && rpt_r != 2'h0 && $past(rpt_r, 3) == rpt_r
        |-> hit_r[1]) else $error("series result moved early");
    a_result_hold: assert property (
        $changed(o_result) |-> $past(i_conv_done, 2))
        else $error("result changed without conversion");
endmodule

bind arf_top arf_top_sva #(
    .SAMPLE_W (SAMPLE_W),
    .RESULT_W (RESULT_W)
) u_sva (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_apb_req   (i_apb_req),
    .i_conv_done (i_conv_done),
    .i_conv_code (i_conv_code),
    .o_apb_rsp   (o_apb_rsp),
    .o_result    (o_result)
);

// ---- bench/tb.sv ----
// self-checking testbench for the converter result formatter
`timescale 1ns/1ps
module tb;
    import arf_pkg::*;
    typedef struct packed {logic [31:0] d; logic e;} arf_note_t;

    logic         i_clk_sys = 1'b0;
    logic         i_rst_n;
    logic         i_conv_done;
    logic [11:0]  i_conv_code;
    arf_apb_req_t i_apb_req;
    arf_apb_rsp_t o_apb_rsp;
    logic [15:0]  o_result;
    int           fail_count = 0;
    int           checks = 0;
    int           cyc = 0;
    int           seed = 3;
    arf_note_t    apb_q[$];
    logic [15:0]  res_q[$];
    logic [15:0]  last_res = 16'h0000;
    logic [15:0]  prev_res = 16'h0000;
    logic [15:0]  acc;
    logic [11:0]  c;
    logic [11:0]  tbl[4] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000};

    arf_top dut_u (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_apb_req   (i_apb_req),
        .i_conv_done (i_conv_done),
        .i_conv_code (i_conv_code),
        .o_apb_rsp   (o_apb_rsp),
        .o_result    (o_result)
    );

    always #5 i_clk_sys = ~i_clk_sys;

    // ****************************************
    // compare, report and drivers
    // ****************************************
    task automatic cmp_apb(input arf_note_t exp, input arf_note_t got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error apb_rsp expected %h seen %h", exp, got);
        end
    endtask

    task automatic cmp_res(input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error o_result expected %h seen %h", exp, got);
        end
    endtask

    task automatic print_verdict;
        if (res_q.size() != 0)
        begin
            fail_count++;
            $display("Error res_q expected 0 seen %0d", res_q.size());
        end
        $display("fail_count %0d checks %0d", fail_count, checks);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // equal consecutive results show no change at the port
    task automatic push_res(input logic [15:0] v);
        if (v !== last_res)
        begin
            res_q.push_back(v);
            last_res = v;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] ex,
                       input logic er);
        apb_q.push_back({ex, er});
        @(posedge i_clk_sys);
        i_apb_req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
        @(posedge i_clk_sys);
        i_apb_req.penable <= 1'b1;
        // only the bench timeout ends a wait that never sees pready
        do
        begin
            @(posedge i_clk_sys);
        end
        while (o_apb_rsp.pready !== 1'b1);
        i_apb_req.psel    <= 1'b0;
        i_apb_req.penable <= 1'b0;
    endtask

    task automatic conv(input logic [11:0] code);
        @(posedge i_clk_sys);
        i_conv_done <= 1'b1;
        i_conv_code <= code;
    endtask

    // the code bus wanders while no conversion is flagged
    task automatic idle(input int k);
        repeat (k)
        begin
            @(posedge i_clk_sys);
            i_conv_done <= 1'b0;
            i_conv_code <= 12'($random(seed));
        end
    endtask

    // ****************************************
    // monitors and timeout
    // ****************************************
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (i_rst_n === 1'b1 && o_apb_rsp.pready === 1'b1)
            cmp_apb(apb_q.size() ? apb_q.pop_front() : '1,
                    {o_apb_rsp.prdata, o_apb_rsp.pslverr});
        if (i_rst_n === 1'b1 && o_result !== prev_res)
            cmp_res(res_q.size() ? res_q.pop_front() : 16'hXXXX,
                    o_result);
        prev_res = o_result;
        if (cyc == 20000)
        begin
            fail_count++;
            $display("Error timeout expected done seen hang");
            print_verdict;
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        i_rst_n     = 1'b0;
        i_apb_req   = '0;
        i_conv_done = 1'b0;
        i_conv_code = 12'h000;
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        apb(0, ARF_OFF_CTRL, 0, 0, 0);
        apb(0, ARF_OFF_CFG, 0, 0, 0);
        apb(0, ARF_OFF_RES_HI, 0, 0, 0);
        apb(0, ARF_OFF_RES_LO, 0, 0, 0);
        apb(0, ARF_OFF_STATUS, 0, 0, 0);
        apb(0, 8'h14, 0, 0, 1);
        apb(1, ARF_OFF_RES_HI, 32'hFF, 0, 1);
        for (int lj = 0; lj < 2; lj++)
        begin
            apb(1, ARF_OFF_CTRL, 32'(lj) << ARF_LJST_BIT, 0, 0);
            for (int i = 0; i < 8; i++)
            begin
                c = (i < 4) ? tbl[i] : 12'($random(seed));
                conv(c);
                push_res(lj ? {c, 4'h0} : {4'h0, c});
                idle(4);
            end
            apb(0, ARF_OFF_RES_HI, 0, {24'h0, last_res[15:8]}, 0);
            apb(0, ARF_OFF_RES_LO, 0, {24'h0, last_res[7:0]}, 0);
        end
        apb(1, ARF_OFF_CTRL, 0, 0, 0);
        for (int r = 1; r < 4; r++)
        begin
            apb(1, ARF_OFF_CFG, r, 0, 0);
            for (int p = 0; p < 2; p++)
            begin
                acc = 16'h0000;
                for (int i = 0; i < (2 << r); i++)
                begin
                    c = p ? 12'($random(seed)) : 12'hFFF;
                    conv(c);
                    acc = acc + {4'h0, c};
                end
                idle(1);
                push_res(acc);
                idle(4);
            end
        end
        apb(1, ARF_OFF_CFG, 1, 0, 0);
        conv(12'h123);
        conv(12'h456);
        idle(1);
        apb(0, ARF_OFF_STATUS, 0, 32'h00000312, 0);
        apb(1, ARF_OFF_CTRL, 32'h1 << ARF_RESTART_BIT, 0, 0);
        acc = 16'h0000;
        for (int i = 0; i < 4; i++)
        begin
            c = 12'($random(seed));
            conv(c);
            acc = acc + {4'h0, c};
        end
        idle(1);
        push_res(acc);
        idle(4);
        apb(0, ARF_OFF_RES_HI, 0, {24'h0, last_res[15:8]}, 0);
        apb(0, ARF_OFF_RES_LO, 0, {24'h0, last_res[7:0]}, 0);
        apb(0, ARF_OFF_STATUS, 0, 32'h00000300, 0);
        apb(1, ARF_OFF_STATUS, 32'h00000300, 0, 0);
        apb(0, ARF_OFF_STATUS, 0, 32'h00000000, 0);
        idle(4);
        print_verdict;
    end
endmodule
